//--- include/sep_pkg.sv
// Purpose: shared constants and types for the serial memory read slave
// Assumes: two-wire bus sampled by SYS_CLK, bus clock much slower than SYS_CLK
// Notes: the device-type code is a parameter of the top module
`default_nettype none

package sep_pkg;

  // ==========================================================
  // sizes and counts
  localparam int SEP_BYTE_BITS = 8;
  localparam logic [3:0] SEP_BIT_CNT_LAST = 4'h8;
  localparam logic [3:0] SEP_BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] SEP_BIT_CNT_ONE = 4'h1;

  // ==========================================================
  // values after reset
  localparam logic SEP_RST_LINE = 1'h1;
  localparam logic [7:0] SEP_RST_BYTE = 8'h00;

  // ==========================================================
  // states
  typedef enum logic [2:0] {
    SEP_ST_IDLE,
    SEP_ST_RX,
    SEP_ST_ACK,
    SEP_ST_TX,
    SEP_ST_MACK
  } sep_state_type;

  typedef enum logic [1:0] {
    SEP_PH_CTRL,
    SEP_PH_WADDR,
    SEP_PH_WDATA
  } sep_phase_type;

endpackage

`default_nettype wire

//--- verilog/sep_mem.sv
// Purpose: small word memory with registered read data
// Assumes: one write port from local fill logic, one read port
// Notes: read data lag the address by one clock
`default_nettype none

module sep_mem #(
  parameter int AW = 4,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  import sep_pkg::*;

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ==========================================================
  // storage, no reset on the array to keep it a plain ram
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ==========================================================
  // registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= DW'(SEP_RST_BYTE);
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

//--- verilog/sep_slave.sv
// Purpose: two-wire read slave in front of a small serial data memory
// Assumes: SCL and SDA_IN come from pins; bus half period is at least 4 clocks
// Notes: write data bytes after the word address are acknowledged and dropped
`default_nettype none

module sep_slave #(
  parameter int AW = 4,
  parameter logic [3:0] DEV_CODE = 4'h6 // arbitrary value
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic PROG_MODE,
  input wire logic LOAD_EN,
  input wire logic [AW-1:0] LOAD_ADDR,
  input wire logic [7:0] LOAD_DATA,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic BUSY,
  output logic [AW-1:0] ADDR_PTR
);
  import sep_pkg::*;

  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    logic prog1;
    logic prog2;
    sep_state_type state;
    sep_phase_type phase;
    logic rd;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] txbyte;
    logic [AW-1:0] addr;
    logic oe;
    logic busy;
  } sep_reg_type;

  sep_reg_type q;
  sep_reg_type next_q;
  logic [7:0] rdata;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic match;
  logic byte_done;

  // ==========================================================
  // memory
  sep_mem #(
    .AW(AW),
    .DW(SEP_BYTE_BITS)
  ) u_mem (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .wr_en(LOAD_EN),
    .wr_addr(LOAD_ADDR),
    .wr_data(LOAD_DATA),
    .rd_addr(q.addr),
    .rd_data(rdata)
  );

  // ==========================================================
  // bus events, read only from the second and third sampling stages
  assign scl_rise = q.scl2 && !q.scl3;
  assign scl_fall = !q.scl2 && q.scl3;
  assign start_det = q.scl2 && q.scl3 && !q.sda2 && q.sda3;
  assign stop_det = q.scl2 && q.scl3 && q.sda2 && !q.sda3;
  // low three address bits are never looked at
  assign match = (q.shreg[7:4] == DEV_CODE);
  assign byte_done = scl_fall && (q.cnt == SEP_BIT_CNT_LAST);

  // ==========================================================
  // next state
  always_comb begin
    next_q = q;
    next_q.scl1 = SCL;
    next_q.scl2 = q.scl1;
    next_q.scl3 = q.scl2;
    next_q.sda1 = SDA_IN;
    next_q.sda2 = q.sda1;
    next_q.sda3 = q.sda2;
    next_q.prog1 = PROG_MODE;
    next_q.prog2 = q.prog1;
    if (stop_det) begin
      // device lets go of the line at once
      next_q.state = SEP_ST_IDLE;
      next_q.oe = 1'b0;
    end else if (start_det) begin
      // a repeated start aborts any write; the pointer keeps its value
      next_q.state = SEP_ST_RX;
      next_q.phase = SEP_PH_CTRL;
      next_q.cnt = SEP_BIT_CNT_ZERO;
      next_q.oe = 1'b0;
    end else begin
      unique case (q.state)
        SEP_ST_IDLE: begin
          next_q.oe = 1'b0;
        end
        SEP_ST_RX: begin
          if (scl_rise && q.cnt != SEP_BIT_CNT_LAST) begin
            next_q.shreg = {q.shreg[6:0], q.sda2};
            next_q.cnt = q.cnt + SEP_BIT_CNT_ONE;
          end else if (byte_done) begin
            unique case (q.phase)
              SEP_PH_CTRL: begin
                if (match && !q.prog2) begin
                  next_q.oe = 1'b1;
                  next_q.state = SEP_ST_ACK;
                  next_q.rd = q.shreg[0];
                  next_q.phase = SEP_PH_WADDR;
                end else begin
                  // other slaves or programming: stay off the line
                  next_q.oe = 1'b0;
                  next_q.state = SEP_ST_IDLE;
                end
              end
              SEP_PH_WADDR: begin
                next_q.addr = q.shreg[AW-1:0];
                next_q.oe = 1'b1;
                next_q.state = SEP_ST_ACK;
                next_q.rd = 1'b0;
                next_q.phase = SEP_PH_WDATA;
              end
              SEP_PH_WDATA: begin
                next_q.oe = 1'b1;
                next_q.state = SEP_ST_ACK;
                next_q.rd = 1'b0;
              end
              default: begin
                next_q.state = SEP_ST_IDLE;
              end
            endcase
          end
        end
        SEP_ST_ACK: begin
          if (scl_fall) begin
            if (q.rd) begin
              // first bit goes out as the ack slot closes
              next_q.txbyte = {rdata[6:0], 1'b0};
              next_q.oe = !rdata[7];
              next_q.cnt = SEP_BIT_CNT_ONE;
              next_q.state = SEP_ST_TX;
            end else begin
              next_q.oe = 1'b0;
              next_q.cnt = SEP_BIT_CNT_ZERO;
              next_q.state = SEP_ST_RX;
            end
          end
        end
        SEP_ST_TX: begin
          if (byte_done) begin
            next_q.oe = 1'b0;
            // add wraps in AW bits, so the top word is followed by word zero
            next_q.addr = q.addr + AW'(1);
            next_q.state = SEP_ST_MACK;
          end else if (scl_fall) begin
            next_q.oe = !q.txbyte[7];
            next_q.txbyte = {q.txbyte[6:0], 1'b0};
            next_q.cnt = q.cnt + SEP_BIT_CNT_ONE;
          end
        end
        SEP_ST_MACK: begin
          if (scl_rise) begin
            if (!q.sda2) begin
              // master wants another word, read data is ready by the fall
              next_q.state = SEP_ST_ACK;
              next_q.rd = 1'b1;
            end else begin
              next_q.state = SEP_ST_IDLE;
            end
          end
        end
      endcase
    end
    next_q.busy = (next_q.state != SEP_ST_IDLE);
  end

  // ==========================================================
  // state register
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '{
        scl1: SEP_RST_LINE,
        scl2: SEP_RST_LINE,
        scl3: SEP_RST_LINE,
        sda1: SEP_RST_LINE,
        sda2: SEP_RST_LINE,
        sda3: SEP_RST_LINE,
        prog1: 1'b0,
        prog2: 1'b0,
        state: SEP_ST_IDLE,
        phase: SEP_PH_CTRL,
        rd: 1'b0,
        cnt: SEP_BIT_CNT_ZERO,
        shreg: SEP_RST_BYTE,
        txbyte: SEP_RST_BYTE,
        addr: '0,
        oe: 1'b0,
        busy: 1'b0
      };
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs, open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = q.oe;
  assign BUSY = q.busy;
  assign ADDR_PTR = q.addr;

  // ==========================================================
  // checks
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  a_idle_released: assert property (
    q.state == SEP_ST_IDLE |-> !q.oe
  ) else $error("data line driven while idle");

  a_stop_release: assert property (
    stop_det |=> (!q.oe && q.state == SEP_ST_IDLE)
  ) else $error("stop did not release the line");

  a_nack_ends: assert property (
    (q.state == SEP_ST_MACK && scl_rise && q.sda2 && !start_det && !stop_det)
      |=> (q.state == SEP_ST_IDLE) ##1 !q.oe
  ) else $error("master nack did not end the read");

  a_read_incr: assert property (
    (q.state == SEP_ST_TX && byte_done && !start_det && !stop_det)
      |=> (q.addr == AW'($past(q.addr) + AW'(1))) && q.state == SEP_ST_MACK
  ) else $error("pointer not advanced after a read");

  a_waddr_load: assert property (
    (q.state == SEP_ST_RX && q.phase == SEP_PH_WADDR && byte_done && !start_det && !stop_det)
      |=> (q.addr == $past(q.shreg[AW-1:0])) && q.oe
  ) else $error("word address not loaded");

  a_ack_match: assert property (
    (q.state == SEP_ST_RX && q.phase == SEP_PH_CTRL && byte_done && match && !q.prog2
      && !start_det && !stop_det) |=> (q.oe && q.state == SEP_ST_ACK)
  ) else $error("matching control byte not acknowledged");

  a_mismatch_quiet: assert property (
    (q.state == SEP_ST_RX && q.phase == SEP_PH_CTRL && byte_done && (!match || q.prog2)
      && !start_det && !stop_det) |=> (!q.oe [*3])
  ) else $error("line driven for another address");

  a_read_select: assert property (
    (q.state == SEP_ST_RX && q.phase == SEP_PH_CTRL && byte_done && match && !q.prog2
      && !start_det && !stop_det) |=> (q.rd == $past(q.shreg[0]))
  ) else $error("read bit not decoded");

  a_first_bit: assert property (
    (q.state == SEP_ST_ACK && q.rd && scl_fall && !start_det && !stop_det)
      |=> (q.state == SEP_ST_TX && q.oe == !$past(rdata[7]))
  ) else $error("first data bit wrong");

  a_ack_more: assert property (
    (q.state == SEP_ST_MACK && scl_rise && !q.sda2 && !start_det && !stop_det)
      |=> (q.state == SEP_ST_ACK && q.rd)
  ) else $error("master ack did not continue the read");

endmodule

`default_nettype wire

//--- testbench/sep_master_model.sv
// Purpose: behavioural two-wire bus master for the read slave
// Assumes: pull-up on the data line; SCL half period of 4 clocks
// Notes: SCL stands high between frames
`default_nettype none

module sep_master_model (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sda_m;

  // ==========================================================
  // wire level
  // pull-up: a released line reads high, either side may pull low
  assign sda = sda_m & ~sda_oe;

  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
  end

  // ==========================================================
  // bus conditions and bits
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  // release first, so a repeated start never clips the slave ack
  task automatic start();
    sda_m <= 1'h1;
    w(4);
    scl <= 1'h1;
    w(4);
    sda_m <= 1'h0;
    w(4);
    scl <= 1'h0;
    w(2);
  endtask

  task automatic stop();
    sda_m <= 1'h0;
    w(2);
    scl <= 1'h1;
    w(4);
    sda_m <= 1'h1;
    w(4);
  endtask

  task automatic put_bit(input logic b);
    sda_m <= b;
    w(2);
    scl <= 1'h1;
    w(4);
    scl <= 1'h0;
    w(2);
  endtask

  task automatic get_bit(output logic b);
    sda_m <= 1'h1;
    w(2);
    scl <= 1'h1;
    w(2);
    b = sda;
    w(2);
    scl <= 1'h0;
    w(2);
  endtask

  // ==========================================================
  // bytes, msb first
  task automatic send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack);
    ack = ~ack;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(~ack);
  endtask
endmodule

`default_nettype wire

//--- testbench/serial_eeprom_read_slave_tb.sv
// Purpose: self-checking bench for the two-wire read slave
// Assumes: AW of 4, memory filled through the load port first
// Notes: bus clock period 160 ns, 8 system clocks
`default_nettype none

module serial_eeprom_read_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] DEV = 4'h6; // arbitrary value
  logic clk, rst_n, scl, sda, prog_mode, load_en, sda_out, sda_oe, busy, seen_oe;
  logic [3:0] load_addr, addr_ptr;
  logic [7:0] load_data;
  int n_fail, tests_run, cycles;

  sep_slave #(.AW(4), .DEV_CODE(DEV)) sep_slave_i (.SYS_CLK(clk), .RST_N(rst_n), .SCL(scl),
    .SDA_IN(sda), .PROG_MODE(prog_mode), .LOAD_EN(load_en), .LOAD_ADDR(load_addr),
    .LOAD_DATA(load_data), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .BUSY(busy), .ADDR_PTR(addr_ptr));
  sep_master_model sep_master_model_i (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  // ==========================================================
  // helpers
  function automatic logic [7:0] word(input logic [3:0] a);
    return {~a, a};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic ctrl(input logic [7:0] b, input logic exp);
    logic a;
    sep_master_model_i.send_byte(b, a);
    check("ack", {7'h00, a}, {7'h00, exp});
    check("busy after ack", {7'h00, busy}, {7'h00, exp});
  endtask

  // word address written, then repeated start
  task automatic set_addr(input logic [3:0] a);
    sep_master_model_i.start();
    ctrl({DEV, 3'h5, 1'h0}, 1'h1);
    ctrl({4'h0, a}, 1'h1);
    sep_master_model_i.start();
  endtask

  task automatic rd_seq(input logic [3:0] a, input int n, input logic [3:0] nxt);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      sep_master_model_i.recv_byte(i < n - 1, d);
      check("data", d, word(a + i[3:0]));
    end
    sep_master_model_i.stop();
    check("pointer", {4'h0, addr_ptr}, {4'h0, nxt});
    check("busy", {7'h00, busy}, 8'h00);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    check("reset ptr", {4'h0, addr_ptr}, 8'h00);
    check("reset oe", {6'h00, busy, sda_oe}, 8'h00);
    check("pull level", {7'h00, sda_out}, 8'h00);
  endtask

  task automatic t_load();
    for (int a = 0; a < 16; a++) begin
      @(posedge clk);
      load_en <= 1'h1;
      load_addr <= a[3:0];
      load_data <= word(a[3:0]);
      @(posedge clk);
      load_en <= 1'h0;
    end
    @(posedge clk);
    check("load ptr", {4'h0, addr_ptr}, 8'h00);
    check("load busy", {7'h00, busy}, 8'h00);
  endtask

  task automatic t_random();
    set_addr(4'h5);
    ctrl({DEV, 3'h7, 1'h1}, 1'h1);
    rd_seq(4'h5, 1, 4'h6);
  endtask

  task automatic t_current();
    sep_master_model_i.start();
    ctrl({DEV, 3'h2, 1'h1}, 1'h1);
    rd_seq(4'h6, 1, 4'h7);
  endtask

  // sequential read across the top of memory
  task automatic t_seq_wrap();
    set_addr(4'hE);
    ctrl({DEV, 3'h0, 1'h1}, 1'h1);
    rd_seq(4'hE, 3, 4'h1);
  endtask

  task automatic t_refused(input logic pm, input logic [3:0] code);
    seen_oe = 1'h0;
    prog_mode <= pm;
    sep_master_model_i.start();
    ctrl({code, 3'h0, 1'h1}, 1'h0);
    sep_master_model_i.stop();
    prog_mode <= 1'h0;
    check("line idle", {7'h00, seen_oe}, 8'h00);
    check("busy", {7'h00, busy}, 8'h00);
    check("ptr kept", {4'h0, addr_ptr}, 8'h01);
  endtask

  // ==========================================================
  // clock, watch, timeout, main
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (sda_oe === 1'h1) seen_oe <= 1'h1;
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    seen_oe = 1'h0;
    rst_n = 1'h0;
    prog_mode = 1'h0;
    load_en = 1'h0;
    load_addr = 4'h0;
    load_data = 8'h00;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    t_reset();
    t_load();
    t_random();
    t_current();
    t_seq_wrap();
    t_refused(1'h0, DEV ^ 4'h1);
    t_refused(1'h0, DEV ^ 4'h8);
    t_refused(1'h1, DEV);
    finish_test();
  end
endmodule

`default_nettype wire
